//--- core/srap_regs.vh
`ifndef SRAP_REGS_VH
`define SRAP_REGS_VH
`define SRAP_FRAME_BITS 24
`define SRAP_CNT_W 5
`define SRAP_DIR_BIT 23
`define SRAP_ADDR_HI 22
`define SRAP_ADDR_LO 16
`define SRAP_DATA_HI 15
`define SRAP_DATA_LO 0
`define SRAP_ADDR_W 7
`define SRAP_DATA_W 16
`define SRAP_IF_NONE 2'h0
`define SRAP_IF_SPI 2'h1
`define SRAP_IF_OTHER 2'h2
`endif

//--- core/srap_port.v
// Contract
// RULE_01: interface type locked by first traffic
// RULE_02: select low interval forms one frame
// RULE_03: input sampled on serial clock falling edge
// RULE_04: frames under 24 edges are discarded
// RULE_05: three-wire uses first 24 bits only
// RULE_06: select high blocks inputs, output released
// RULE_07: output disabled after reset, write-only
// RULE_08: bit 23 is direction, one means read
// RULE_09: bits 22..16 give register address
// RULE_10: bits 15..0 data, written on write
// RULE_11: host enables output before reading
// RULE_12: read data returns in following frame
// RULE_13: echo direction, address and read data
// RULE_14: output edge chosen by select bit
// RULE_15: four-wire acts on last 24 bits
// RULE_16: four-wire drops non-multiple-of-24 frames
// RULE_17: host slows clock for readback
// RULE_18: output only when pin set for it
// RULE_19: host wires chain input to output
// RULE_20: previous frame shifted out every frame
// RULE_21: most significant bit first both ways
`timescale 1ns/1ps
`default_nettype none
`include "srap_regs.vh"
module srap_port #(
	parameter FRAME_BITS = `SRAP_FRAME_BITS
)(
	input wire clk,
	input wire nrst,
	input wire sclk,
	input wire sync_n,
	input wire sdi,
	input wire other_if_seen,
	input wire readback_output_enable,
	input wire output_edge_select,
	input wire gpio_is_sdo,
	input wire [15:0] rd_data,
	output reg sdo_o,
	output reg sdo_oe_n,
	output reg wr_stb,
	output reg [6:0] reg_addr,
	output reg [15:0] frame_payload_field,
	output reg rd_stb,
	output reg [1:0] if_type
);
////////////////////////////////////////////////////////////////////////
// reset release
reg rst_a_q, rst_b_q;
always @(posedge clk or negedge nrst)
	if (!nrst)
	begin
		rst_a_q <= 1'b0;
		rst_b_q <= 1'b0;
	end
	else
	begin
		rst_a_q <= 1'b1;
		rst_b_q <= rst_a_q;
	end
wire rst_n = rst_b_q;
////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg [2:0] sclk_s_q, sync_s_q, sdi_s_q, oth_s_q;
always @(posedge clk or negedge rst_n)
	if (!rst_n)
	begin
		sclk_s_q <= 3'h0;
		sync_s_q <= 3'h7;
		sdi_s_q <= 3'h0;
		oth_s_q <= 3'h0;
	end
	else
	begin
		sclk_s_q <= {sclk_s_q[1:0], sclk};
		sync_s_q <= {sync_s_q[1:0], sync_n};
		sdi_s_q <= {sdi_s_q[1:0], sdi};
		oth_s_q <= {oth_s_q[1:0], other_if_seen};
	end
wire sc = sclk_s_q[1];
wire sc_prev = sclk_s_q[2];
wire sel = ~sync_s_q[1];
wire sel_prev = ~sync_s_q[2];
wire din = sdi_s_q[1];
wire fall = sc_prev & ~sc;
wire rise = ~sc_prev & sc;
wire frame_end = sel_prev & ~sel;
////////////////////////////////////////////////////////////////////////
// frame state
reg [23:0] sh_q, first_q, prev_q, out_q;
reg [4:0] mod_q;
reg [1:0] blk_q;
reg four_q;
// RULE_01 only spi or undecided traffic counts
wire active = (if_type == `SRAP_IF_SPI) || (if_type == `SRAP_IF_NONE);
wire frame_start = sel & ~sel_prev;
// RULE_06 clock and data blocked when deselected
wire bit_in = sel & fall & active;
wire [23:0] sh_d = {sh_q[22:0], din};
wire full_frame = (mod_q == FRAME_BITS - 1);
wire four_w = readback_output_enable & gpio_is_sdo;
// RULE_05 RULE_15 first or last 24 bits
wire [23:0] chosen = four_q ? sh_q : first_q;
// RULE_16 multiple of 24 check
wire ok4 = (mod_q == 5'h00) && (blk_q != 2'h0);
// RULE_04 minimum length
wire ok3 = (blk_q != 2'h0);
wire frame_ok = four_q ? ok4 : ok3;
// RULE_02 act when select rises
wire take = frame_end & active & frame_ok;
// RULE_14 launch edge select
wire launch = sel & active & (output_edge_select ? rise : fall);
////////////////////////////////////////////////////////////////////////
// direction flag of a frame
function is_read;
	input [23:0] f;
	begin
		is_read = f[`SRAP_DIR_BIT];
	end
endfunction
////////////////////////////////////////////////////////////////////////
// input shift register and edge counters
always @(posedge clk or negedge rst_n)
	if (!rst_n)
	begin
		sh_q <= 24'h000000;
		first_q <= 24'h000000;
		mod_q <= 5'h00;
		blk_q <= 2'h0;
		four_q <= 1'b0;
	end
	else if (frame_start)
	begin
		mod_q <= 5'h00;
		blk_q <= 2'h0;
		// RULE_18 four-wire fixed for the frame
		four_q <= four_w;
	end
	// RULE_03 RULE_21 capture msb first on falls
	else if (bit_in)
	begin
		sh_q <= sh_d;
		if (full_frame)
		begin
			mod_q <= 5'h00;
			if (blk_q == 2'h0)
				first_q <= sh_d;
			if (blk_q != 2'h3)
				blk_q <= blk_q + 2'h1;
		end
		else
			mod_q <= mod_q + 5'h01;
	end
////////////////////////////////////////////////////////////////////////
// interface type lock
always @(posedge clk or negedge rst_n)
	if (!rst_n)
		if_type <= `SRAP_IF_NONE;
	// RULE_01 first protocol locks the type
	else if (if_type == `SRAP_IF_NONE)
	begin
		if (take)
			if_type <= `SRAP_IF_SPI;
		else if (oth_s_q[1] && !sel)
			if_type <= `SRAP_IF_OTHER;
	end
////////////////////////////////////////////////////////////////////////
// frame decode and strobes
always @(posedge clk or negedge rst_n)
	if (!rst_n)
	begin
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		reg_addr <= 7'h00;
		frame_payload_field <= 16'h0000;
		prev_q <= 24'h000000;
	end
	else
	begin
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		if (take)
		begin
			// RULE_09 register address
			reg_addr <= chosen[`SRAP_ADDR_HI:`SRAP_ADDR_LO];
			// RULE_10 data field
			frame_payload_field <= chosen[`SRAP_DATA_HI:`SRAP_DATA_LO];
			// RULE_08 direction bit
			wr_stb <= ~is_read(chosen);
			rd_stb <= is_read(chosen);
			// RULE_13 echo with read data
			if (is_read(chosen))
				prev_q <= {chosen[23:16], rd_data};
			else
				prev_q <= chosen;
		end
	end
////////////////////////////////////////////////////////////////////////
// serial output shifter
always @(posedge clk or negedge rst_n)
	if (!rst_n)
	begin
		out_q <= 24'h000000;
		sdo_o <= 1'b0;
		sdo_oe_n <= 1'b1;
	end
	else
	begin
		// RULE_20 previous frame leads the output
		if (frame_start)
			out_q <= prev_q;
		// RULE_20 received bits follow along the chain
		else if (bit_in)
			out_q <= {out_q[22:0], din};
		if (frame_start)
			sdo_o <= prev_q[23];
		else if (launch)
			sdo_o <= out_q[23];
		// RULE_06 RULE_07 RULE_18 output enable
		sdo_oe_n <= ~(sel && four_w && active);
	end
endmodule // srap_port
`default_nettype wire

//--- tb/srap_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module srap_port_checker(
	input wire logic clk,
	input wire logic nrst,
	input wire logic sync_n,
	input wire logic gpio_is_sdo,
	input wire logic sdo_oe_n,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [1:0] if_type
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	idle_hiz_a: assert property (sync_n[*6] |-> sdo_oe_n) else $error("oe idle");
	pin_off_a: assert property (!gpio_is_sdo[*4] |-> sdo_oe_n) else $error("oe pin");
	one_op_a: assert property (!(wr_stb && rd_stb)) else $error("two ops");
	wr_pulse_a: assert property (wr_stb |=> !wr_stb) else $error("wr long");
	rd_pulse_a: assert property (rd_stb |=> !rd_stb) else $error("rd long");
	frame_end_a: assert property (wr_stb |-> sync_n) else $error("wr early");
	type_lock_a: assert property (if_type != 2'h0 |=> $stable(if_type)) else $error("type");
	spi_only_a: assert property (rd_stb |-> if_type == 2'h1) else $error("rd type");
endmodule // srap_port_checker
bind srap_port srap_port_checker srap_port_checker_inst(.*);
`default_nettype wire

//--- tb/srap_host.sv
`timescale 1ns/1ps
`default_nettype none
module srap_host(
	output logic sclk = 1,
	output logic sync_n = 1,
	output logic sdi = 1,
	input wire logic output_edge_select,
	input wire logic sdo
);
	logic [47:0] rx;
	// fixed 200 ns period suits readback
	task automatic xfer(input logic [47:0] v, input int n);
		sync_n = 0;
		for (int i = n - 1; i >= 0; i--)
		begin
			sdi = v[i];
			#100;
			if (output_edge_select) rx = {rx[46:0], sdo};
			sclk = 0;
			#100 sclk = 1;
			if (!output_edge_select) rx = {rx[46:0], sdo};
		end
		#100 sync_n = 1;
		sdi = ~sdi;
		#900;
	endtask
endmodule // srap_host
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("BAD %0t %h", $time, a); end end
module tb_top;
	logic clk = 0, nrst = 0, readback_output_enable = 0, gpio_is_sdo = 0;
	logic other_if_seen = 0, output_edge_select = 0;
	logic [15:0] rd_data = 16'hBEEF;
	wire sclk, sync_n, sdi, sdo_o, sdo_oe_n, wr_stb, rd_stb;
	wire sdo = sdo_oe_n ? ~sdo_o : sdo_o;
	wire [6:0] reg_addr;
	wire [15:0] frame_payload_field;
	wire [1:0] if_type;
	int miscompares = 0, n_checks = 0;
	integer nwr = 0, nrd = 0;
	logic [24:0] rows[3] = '{25'h0051234, 25'h07F0001, 25'h1800000};
	srap_port srap_port_inst(.*);
	srap_host srap_host_inst(.*);
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin nwr += wr_stb; nrd += rd_stb; end
	task automatic frm(input logic [47:0] v, input int n, ew, er);
		int w0, r0;
		w0 = nwr;
		r0 = nrd;
		srap_host_inst.xfer(v, n);
		`CHK(nwr - w0, ew)
		`CHK(nrd - r0, er)
	endtask
	task end_sim;
		$display("checks %0d bad %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin #300000; miscompares++; end_sim; end
	initial
	begin
		repeat (10) @(posedge clk);
		`CHK(sdo_oe_n, 1'b1)
		#2 nrst = 1;
		repeat (4) @(posedge clk);
		foreach (rows[i])
		begin
			frm(rows[i][23:0], 24, !rows[i][24], rows[i][24]);
			`CHK(reg_addr, rows[i][22:16])
			if (!rows[i][24]) `CHK(frame_payload_field, rows[i][15:0])
		end
		`CHK(if_type, 2'h1)
		$display("rows done");
		frm(48'h0, 23, 0, 0);
		frm({24'h125A5A, 6'h3F}, 30, 1, 0);
		`CHK(frame_payload_field, 16'h5A5A)
		@(posedge clk);
		#2 readback_output_enable = 1;
		gpio_is_sdo = 1;
		frm(48'h830000, 24, 0, 1);
		frm(48'h030000, 24, 1, 0);
		`CHK(srap_host_inst.rx[23:0], 24'h83BEEF)
		frm({24'h111111, 24'h222222}, 48, 1, 0);
		`CHK(reg_addr, 7'h22)
		`CHK(srap_host_inst.rx[47:24], 24'h030000)
		`CHK(srap_host_inst.rx[23:0], 24'h111111)
		@(posedge clk);
		#2 output_edge_select = 1;
		other_if_seen = 1;
		frm(48'h044321, 24, 1, 0);
		`CHK(srap_host_inst.rx[23:0], 24'h222222)
		`CHK(if_type, 2'h1)
		frm(48'h0, 30, 0, 0);
		`CHK(sdo_oe_n, 1'b1)
		$display("edge cases done");
		end_sim;
	end
endmodule // tb_top
`default_nettype wire
